//--- pkg/pgpld_pkg.sv
// Constants and types for the page register and programmable decode block
package pgpld_pkg;
    // Host bus flavours; Gray order along mux, nonmux, burst
    typedef enum logic [1:0] {
        PGPLD_BUS_MUX = 2'h0,    // WR/RD/fetch strobes, address latch
        PGPLD_BUS_NONMUX = 2'h1, // Address direct, data on port A
        PGPLD_BUS_BURST = 2'h3,  // Muxed, upper address latched, A3:0 live
        PGPLD_BUS_RW_E = 2'h2    // R/W level plus E strobe, muxed
    } pgpld_bus_t;

    localparam int PGPLD_CLK_NS = 50;     // sys_clk period
    localparam int PGPLD_IDLE_NS = 70;    // Quiet time before standby
    // Least time, rounded up to whole cycles
    localparam int PGPLD_IDLE_CYC =
        (PGPLD_IDLE_NS + PGPLD_CLK_NS - 1) / PGPLD_CLK_NS;

    localparam logic [7:0] PGPLD_PAGE_OFFSET = 8'he0; // memory_page_select
    localparam logic [7:0] PGPLD_PAGE_RESET = 8'h00;
    localparam int PGPLD_BUS_W = 57;            // Input bus signals
    localparam int PGPLD_LIT_W = 2 * PGPLD_BUS_W; // True and inverted
    localparam int PGPLD_MAIN_N = 8;
    localparam int PGPLD_SEC_N = 4;
    localparam int PGPLD_MAIN_PT = 3;
    localparam int PGPLD_SEC_PT = 3;
    localparam int PGPLD_SRAM_PT = 2;
    localparam int PGPLD_SEC_BASE = PGPLD_MAIN_N * PGPLD_MAIN_PT;
    localparam int PGPLD_SRAM_BASE =
        PGPLD_SEC_BASE + PGPLD_SEC_N * PGPLD_SEC_PT;
    localparam int PGPLD_REG_TERM = PGPLD_SRAM_BASE + PGPLD_SRAM_PT;
    localparam int PGPLD_DEC_TERMS = PGPLD_REG_TERM + 1;
    localparam int PGPLD_GEN_N = 19;            // General array outputs
    localparam int PGPLD_GEN_TERMS = 95;        // Sum of per-pin terms
    localparam int PGPLD_GEN_MAXPT = 9;
    // Blocking bits in power_mode_reg_third
    localparam int PGPLD_BLK_CA = 0;
    localparam int PGPLD_BLK_CB = 1;
    localparam int PGPLD_BLK_CC = 2;
    localparam int PGPLD_BLK_AS = 3;
    localparam int PGPLD_BLK_DBE = 4;
    localparam int PGPLD_TURBO_BIT = 3;         // In power_mode_reg_first
endpackage

//--- sim/pgpld_host.sv
// Host bus model: drives address, strobes and write data
module pgpld_host (
    input wire logic sys_clk,
    output logic [19:0] host_addr,
    output logic bus_ctrl_in_a,
    output logic bus_ctrl_in_b,
    output logic bus_ctrl_in_c,
    output logic address_strobe_in,
    output logic [7:0] data_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle bus: strobes inactive, latch closed
    initial begin
        host_addr = 20'h00000;
        bus_ctrl_in_a = 1'b1;
        bus_ctrl_in_b = 1'b1;
        bus_ctrl_in_c = 1'b1;
        address_strobe_in = 1'b0;
        data_in = 8'h00;
    end

    // Latch open across one rising edge, then closed
    task automatic put_addr(input logic [19:0] a);
        @(negedge sys_clk);
        host_addr = a;
        address_strobe_in = 1'b1;
        @(negedge sys_clk);
        address_strobe_in = 1'b0;
    endtask

    // Low on control A means write in every bus type but R/W plus E, where E must also be high
    task automatic write_reg(input logic [19:0] a, input logic [7:0] d);
        put_addr(a);
        data_in = d;
        bus_ctrl_in_a = 1'b0;
        @(negedge sys_clk);
        bus_ctrl_in_a = 1'b1;
        data_in = ~d; // Released bus must not look like held data
    endtask

    // Read strobe held until read_off
    task automatic read_on(input logic [19:0] a);
        put_addr(a);
        bus_ctrl_in_b = 1'b0;
    endtask

    task automatic read_off;
        @(negedge sys_clk);
        bus_ctrl_in_b = 1'b1;
    endtask

    // R/W-plus-E write: R/W low one edge ahead, then E high for one edge
    // E is left low afterwards, the idle level of that bus
    task automatic write_rw_e(input logic [19:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        bus_ctrl_in_b = 1'b0;
        put_addr(a);
        data_in = d;
        bus_ctrl_in_a = 1'b0;
        @(negedge sys_clk);
        bus_ctrl_in_b = 1'b1;
        @(negedge sys_clk);
        bus_ctrl_in_b = 1'b0;
        bus_ctrl_in_a = 1'b1;
        data_in = ~d;
    endtask
endmodule

//--- sim/tb.sv
// Self-checking bench for the page register and decode arrays
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LW = pgpld_pkg::PGPLD_LIT_W;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    pgpld_pkg::pgpld_bus_t bus_type = pgpld_pkg::PGPLD_BUS_MUX;
    wire [19:0] host_addr;
    wire ctl_a, ctl_b, ctl_c, strobe;
    wire [7:0] wdata;
    logic [7:0] port_c = 8'h00; // Port C pins into the arrays
    logic [7:0] port_b = 8'h00; // Port B pins, used as array inputs
    logic [7:0] pm_first = 8'h08; // Turbo on until the standby test
    logic [7:0] pm_third = 8'h00; // Control blocking bits
    logic [18:0] gen_low = 19'h10000; // Pin 16 inverted
    logic [18:0] gen_en = 19'h10001; // Pins 0 and 16 driven
    logic rst_pin = 1'b0;
    logic pdn_pin = 1'b0;
    logic rdy_pin = 1'b0;
    logic [pgpld_pkg::PGPLD_DEC_TERMS*LW-1:0] dec_f;
    logic [pgpld_pkg::PGPLD_GEN_TERMS*LW-1:0] gen_f;
    logic [7:0] data_out, page, main_sel, pa_out, pa_oe, pb_oe, pb_out;
    logic [3:0] sec_sel;
    logic [2:0] pd_out, pd_oe;
    logic rd_oe, sram_sel, reg_sel, standby;
    int miscompares = 0;
    int n_checks = 0;

    // Clock, 50 ns period
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    pgpld_host pgpld_host_inst (.sys_clk(sys_clk), .host_addr(host_addr),
        .bus_ctrl_in_a(ctl_a), .bus_ctrl_in_b(ctl_b),
        .bus_ctrl_in_c(ctl_c), .address_strobe_in(strobe),
        .data_in(wdata));

    pgpld_top pgpld_top_inst (.sys_clk(sys_clk), .arst_n(arst_n),
        .bus_type(bus_type), .host_addr(host_addr), .bus_ctrl_in_a(ctl_a),
        .bus_ctrl_in_b(ctl_b), .bus_ctrl_in_c(ctl_c),
        .address_strobe_in(strobe), .data_bus_enable_in(1'b0),
        .data_in(wdata), .data_out(data_out), .addr_data_oe(rd_oe),
        .device_reset_in(rst_pin), .power_down_input(pdn_pin),
        .flash_ready(rdy_pin), .port_a_in(8'h00), .port_b_in(port_b),
        .port_c_in(port_c), .port_d_in(3'h0), .port_a_out(pa_out),
        .port_a_oe(pa_oe), .port_b_out(pb_out), .port_b_oe(pb_oe),
        .port_d_out(pd_out), .port_d_oe(pd_oe),
        .power_mode_reg_first(pm_first),
        .power_mode_reg_third(pm_third), .dec_fuses(dec_f),
        .gen_fuses(gen_f), .gen_active_low(gen_low), .gen_out_en(gen_en),
        .page_bits(page), .main_flash_select(main_sel),
        .secondary_flash_select(sec_sel), .sram_select(sram_sel),
        .register_space_select(reg_sel), .pld_standby(standby));

    // Compare with four-state equality, count both outcomes
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Literal masks: bus bit i true at i, inverted at 57+i
    task automatic dterm(input int t, input int l0, input int l1);
        dec_f[t*LW +: LW] = '0;
        dec_f[t*LW+l0] = 1'b1;
        dec_f[t*LW+l1] = 1'b1;
    endtask

    task automatic gterm(input int t, input int l0);
        gen_f[t*LW +: LW] = '0;
        gen_f[t*LW+l0] = 1'b1;
    endtask

    // Equations live straight out of reset, page cleared
    task automatic t_reset;
        repeat (2) @(negedge sys_clk);
        chk(page, 8'h00);
        chk(data_out, 8'h00);
        chk(pd_out[0], 1'b1);
    endtask

    // Page ff and 05, wrong offset and wrong space ignored
    task automatic t_page;
        pgpld_host_inst.write_reg(20'h080e0, 8'hff);
        chk(page, 8'hff);
        pgpld_host_inst.write_reg(20'h080e0, 8'h05);
        chk(page, 8'h05);
        @(negedge sys_clk);
        chk(data_out, 8'h05);
        chk(reg_sel, 1'b1);
        pgpld_host_inst.write_reg(20'h080e1, 8'hff);
        chk(page, 8'h05);
        pgpld_host_inst.write_reg(20'h000e0, 8'hff);
        chk(page, 8'h05);
        pgpld_host_inst.read_on(20'h080e0);
        #1 chk(rd_oe, 1'b1);
        pgpld_host_inst.read_off();
        pgpld_host_inst.read_on(20'h080e1);
        #1 chk(rd_oe, 1'b0);
        pgpld_host_inst.read_off();
    endtask

    // Page and port terms, then the overlap priorities
    task automatic t_decode;
        pgpld_host_inst.put_addr(20'h00000);
        @(negedge sys_clk);
        chk(main_sel, 8'h01);
        port_c = 8'h01;
        @(negedge sys_clk);
        chk(main_sel, 8'h03);
        pgpld_host_inst.put_addr(20'h04000);
        @(negedge sys_clk);
        chk(main_sel, 8'h00);
        chk(sec_sel, 4'h1);
        pgpld_host_inst.write_reg(20'h080e0, 8'h07);
        pgpld_host_inst.put_addr(20'h04000);
        @(negedge sys_clk);
        chk(sram_sel, 1'b1);
        chk(sec_sel, 4'h0);
        chk(pa_out[0], 1'b1);
        chk(pa_oe, 8'h01);
        chk(pb_oe, 8'h00);
        chk(pd_out[0], 1'b0);
    endtask

    // Bus modes: burst slice, control blocking, data port, R/W plus E
    // Page c4 keeps the SRAM term off so flash selects are visible
    task automatic t_modes;
        pgpld_host_inst.write_reg(20'h080e0, 8'hc4);
        bus_type = pgpld_pkg::PGPLD_BUS_BURST;
        pgpld_host_inst.put_addr(20'h00010);
        @(negedge sys_clk);
        chk(main_sel, 8'h06);
        bus_type = pgpld_pkg::PGPLD_BUS_MUX;
        repeat (2) @(negedge sys_clk);
        chk(main_sel, 8'h02);
        rst_pin = 1'b1;
        @(negedge sys_clk);
        chk(main_sel, 8'h02);
        pm_third = 8'h04;
        @(negedge sys_clk);
        chk(main_sel, 8'h0a);
        pm_third = 8'h00;
        rst_pin = 1'b0;
        bus_type = pgpld_pkg::PGPLD_BUS_NONMUX;
        repeat (2) @(negedge sys_clk);
        chk(pa_out, 8'hc4);
        pgpld_host_inst.read_on(20'h080e0);
        #1 chk(pa_oe, 8'hff);
        chk(rd_oe, 1'b0);
        pgpld_host_inst.read_off();
        bus_type = pgpld_pkg::PGPLD_BUS_RW_E;
        pgpld_host_inst.write_rw_e(20'h080e0, 8'h3c);
        chk(page, 8'h3c);
    endtask

    // Port pins as array inputs, polarity and output enables
    task automatic t_pins;
        pdn_pin = 1'b1;
        rdy_pin = 1'b1;
        port_b = 8'h01;
        @(negedge sys_clk);
        chk(8'(pd_out), 8'h07);
        chk(pb_out, 8'h01);
        gen_low = 19'h30000;
        gen_en = 19'h6a501;
        @(negedge sys_clk);
        chk(8'(pd_out), 8'h05);
        chk(pb_oe, 8'ha5);
        chk(8'(pd_oe), 8'h06);
    endtask

    // Quiet inputs with turbo off enter standby; a toggle or turbo leaves
    task automatic t_standby;
        pm_first = 8'h00;
        repeat (5) @(negedge sys_clk);
        chk(standby, 1'b1);
        port_c = 8'h03;
        @(negedge sys_clk);
        chk(standby, 1'b0);
        repeat (3) @(negedge sys_clk);
        chk(standby, 1'b1);
        pm_first = 8'h08;
        repeat (2) @(negedge sys_clk);
        chk(standby, 1'b0);
    endtask

    // Reset in mid-run clears a nonzero page at once and after release
    task automatic t_rerst;
        arst_n = 1'b0;
        @(negedge sys_clk);
        chk(page, 8'h00);
        chk(main_sel, 8'h00);
        arst_n = 1'b1;
        @(negedge sys_clk);
        chk(page, 8'h00);
    endtask

    // Every term starts unsatisfiable, then a few are programmed
    initial begin
        for (int t = 0; t < pgpld_pkg::PGPLD_DEC_TERMS; t++) begin
            dterm(t, 0, 57);
        end
        gen_f = '0;
        for (int t = 0; t < pgpld_pkg::PGPLD_GEN_TERMS; t++) begin
            gen_f[t*LW] = 1'b1;
            gen_f[t*LW+57] = 1'b1;
        end
        dterm(0, 1, 113);
        dterm(3, 12, 113);
        dterm(6, 41, 113);
        dterm(24, 55, 113);
        dterm(36, 2, 113);
        dterm(38, 56, 56);
        dterm(9, 37, 95); // Reset pin and inverted third control
        gterm(0, 3);
        gterm(92, 1);
        gterm(48, 20); // Port B pin 0 into general pin 8
        gterm(93, 36); // Power-down into general pin 17
        gterm(94, 0); // Ready flag into general pin 18
        repeat (5) @(negedge sys_clk);
        arst_n = 1'b1;
        t_reset();
        t_page();
        t_decode();
        t_modes();
        t_pins();
        t_standby();
        t_rerst();
        results();
    end

    // Watchdog: the run needs about 75 cycles
    initial begin
        #50000;
        miscompares++;
        results();
    end
endmodule

//--- verilog/pgpld_top.sv
// Page register, decode logic array and general logic array
module pgpld_top (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire pgpld_pkg::pgpld_bus_t bus_type,  // Configured host bus
    input wire logic [19:0] host_addr,           // Address pins
    input wire logic bus_ctrl_in_a,              // WR_n or R/W
    input wire logic bus_ctrl_in_b,              // RD_n or E
    input wire logic bus_ctrl_in_c,              // Fetch strobe, low
    input wire logic address_strobe_in,          // Latch while high
    input wire logic data_bus_enable_in,         // Extra control input
    input wire logic [7:0] data_in,              // Host write data
    output logic [7:0] data_out,                 // Host read data
    output logic addr_data_oe,                   // Drive muxed data pins
    input wire logic device_reset_in,            // Reset pin level
    input wire logic power_down_input,
    input wire logic flash_ready,                // Ready/busy flag
    input wire logic [7:0] port_a_in,
    input wire logic [7:0] port_b_in,
    input wire logic [7:0] port_c_in,
    input wire logic [2:0] port_d_in,
    output logic [7:0] port_a_out,
    output logic [7:0] port_a_oe,
    output logic [7:0] port_b_out,
    output logic [7:0] port_b_oe,
    output logic [2:0] port_d_out,
    output logic [2:0] port_d_oe,
    input wire logic [7:0] power_mode_reg_first,
    input wire logic [7:0] power_mode_reg_third,
    input wire logic [pgpld_pkg::PGPLD_DEC_TERMS*pgpld_pkg::PGPLD_LIT_W-1:0]
        dec_fuses,                               // Decode term masks
    input wire logic [pgpld_pkg::PGPLD_GEN_TERMS*pgpld_pkg::PGPLD_LIT_W-1:0]
        gen_fuses,                               // General term masks
    input wire logic [18:0] gen_active_low,      // Output polarity
    input wire logic [18:0] gen_out_en,          // Pin used as output
    output logic [7:0] page_bits,
    output logic [7:0] main_flash_select,
    output logic [3:0] secondary_flash_select,
    output logic sram_select,
    output logic register_space_select,
    output logic pld_standby
);
    localparam int LW = pgpld_pkg::PGPLD_LIT_W;

    // One product term: every fused literal must be true
    function automatic logic pterm(input logic [LW-1:0] mask,
                                   input logic [LW-1:0] lits);
        return &(lits | ~mask);
    endfunction

    // Product terms for general output pin 0..18
    function automatic int gen_cnt(input int pin);
        if (pin < 4) return 3;
        else if (pin < 8) return 9;
        else if (pin < 12) return 4;
        else if (pin < 16) return 7;
        else return 1;
    endfunction

    // First term index of a general output pin
    function automatic int gen_base(input int pin);
        int b;
        b = 0;
        for (int k = 0; k < pin; k++) b += gen_cnt(k);
        return b;
    endfunction

    logic [19:0] addr_latch;      // Address held by the latch pin
    logic [19:0] eff_addr;        // Address as the block sees it
    logic [15:0] arr_addr;        // Sixteen address lines to arrays
    logic [56:0] in_bus;          // Programmable logic input bus
    logic [LW-1:0] lits;          // True and inverted literals
    logic [LW-1:0] lits_q;        // Previous literals, for idle sensing
    logic [1:0] idle_cnt;         // Quiet cycles seen
    logic wr_act, rd_act, muxed, nonmux;
    logic [7:0] main_raw;
    logic [3:0] sec_raw;
    logic sram_raw, reg_raw, page_hit;
    logic [18:0] gen_raw;

    assign muxed = (bus_type != pgpld_pkg::PGPLD_BUS_NONMUX);
    assign nonmux = ~muxed;

    // Strobe roles follow the configured bus type
    always_comb begin
        if (bus_type == pgpld_pkg::PGPLD_BUS_RW_E) begin
            wr_act = ~bus_ctrl_in_a & bus_ctrl_in_b;
            rd_act = bus_ctrl_in_a & bus_ctrl_in_b;
        end else begin
            wr_act = ~bus_ctrl_in_a;
            rd_act = ~bus_ctrl_in_b | ~bus_ctrl_in_c;
        end
    end

    // Address latch follows the pin while it is high
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_latch <= 20'h00000;
        end else if (address_strobe_in) begin
            addr_latch <= host_addr;
        end
    end

    // Burst keeps the low nibble live; non-muxed uses pins directly
    always_comb begin
        if (nonmux) begin
            eff_addr = host_addr;
        end else if (bus_type == pgpld_pkg::PGPLD_BUS_BURST) begin
            eff_addr = {addr_latch[19:4], host_addr[3:0]};
        end else begin
            eff_addr = addr_latch;
        end
        if (bus_type == pgpld_pkg::PGPLD_BUS_BURST) begin
            arr_addr = eff_addr[19:4];
        end else begin
            arr_addr = eff_addr[15:0];
        end
    end

    // Input bus; blocked controls read as zero to save toggling power
    always_comb begin
        in_bus = {arr_addr,
            bus_ctrl_in_a & ~power_mode_reg_third[pgpld_pkg::PGPLD_BLK_CA],
            bus_ctrl_in_b & ~power_mode_reg_third[pgpld_pkg::PGPLD_BLK_CB],
            bus_ctrl_in_c & ~power_mode_reg_third[pgpld_pkg::PGPLD_BLK_CC],
            device_reset_in, power_down_input,
            port_a_in, port_b_in, port_c_in, port_d_in,
            page_bits, flash_ready};
        lits = {~in_bus, in_bus};
    end

    // The latch and data-enable blocks gate only an unused signal, not what the arrays see
    logic ctrl_extra_unused;
    assign ctrl_extra_unused = address_strobe_in
        & ~power_mode_reg_third[pgpld_pkg::PGPLD_BLK_AS] & data_bus_enable_in
        & ~power_mode_reg_third[pgpld_pkg::PGPLD_BLK_DBE];

    // Decode array; fuse image is live, so selects work from power-up
    always_comb begin
        for (int i = 0; i < pgpld_pkg::PGPLD_MAIN_N; i++) begin
            main_raw[i] = 1'b0;
            for (int t = 0; t < pgpld_pkg::PGPLD_MAIN_PT; t++) begin
                main_raw[i] |= pterm(dec_fuses[
                    (i*pgpld_pkg::PGPLD_MAIN_PT+t)*LW +: LW], lits);
            end
        end
        for (int j = 0; j < pgpld_pkg::PGPLD_SEC_N; j++) begin
            sec_raw[j] = 1'b0;
            for (int t = 0; t < pgpld_pkg::PGPLD_SEC_PT; t++) begin
                sec_raw[j] |= pterm(dec_fuses[(pgpld_pkg::PGPLD_SEC_BASE
                    + j*pgpld_pkg::PGPLD_SEC_PT + t)*LW +: LW], lits);
            end
        end
        sram_raw = 1'b0;
        for (int t = 0; t < pgpld_pkg::PGPLD_SRAM_PT; t++) begin
            sram_raw |= pterm(dec_fuses[
                (pgpld_pkg::PGPLD_SRAM_BASE+t)*LW +: LW], lits);
        end
        reg_raw = pterm(dec_fuses[pgpld_pkg::PGPLD_REG_TERM*LW +: LW], lits);
    end

    assign page_hit = reg_raw
        & (eff_addr[7:0] == pgpld_pkg::PGPLD_PAGE_OFFSET);

    // Registered selects with overlap priority
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            main_flash_select <= 8'h00;
            secondary_flash_select <= 4'h0;
            sram_select <= 1'b0;
            register_space_select <= 1'b0;
        end else begin
            sram_select <= sram_raw;
            register_space_select <= reg_raw;
            secondary_flash_select <= sec_raw & {4{~(sram_raw | reg_raw)}};
            main_flash_select <= main_raw
                & {8{~(|sec_raw | sram_raw | reg_raw)}};
        end
    end

    // Paging register; written while the strobe and select are active
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            page_bits <= pgpld_pkg::PGPLD_PAGE_RESET;
        end else if (wr_act && page_hit) begin
            page_bits <= data_in;
        end
    end

    // Read path: data from flops, enable may follow the strobe directly
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_out <= 8'h00;
        end else begin
            data_out <= page_bits;
        end
    end
    assign addr_data_oe = muxed & rd_act & page_hit;

    // General array sums with per-pin term counts and polarity
    always_comb begin
        for (int p = 0; p < pgpld_pkg::PGPLD_GEN_N; p++) begin
            gen_raw[p] = 1'b0;
            for (int t = 0; t < pgpld_pkg::PGPLD_GEN_MAXPT; t++) begin
                if (t < gen_cnt(p)) begin
                    gen_raw[p] |= pterm(
                        gen_fuses[(gen_base(p)+t)*LW +: LW], lits);
                end
            end
            gen_raw[p] ^= gen_active_low[p];
        end
    end

    // Port outputs; port A turns into the data port on a non-muxed bus
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            port_a_out <= 8'h00;
            port_b_out <= 8'h00;
            port_d_out <= 3'h0;
        end else begin
            port_a_out <= nonmux ? page_bits : gen_raw[7:0];
            port_b_out <= gen_raw[15:8];
            port_d_out <= gen_raw[18:16];
        end
    end
    // Pins not enabled stay free as inputs or for other functions
    assign port_a_oe = nonmux ? {8{rd_act & page_hit}} : gen_out_en[7:0];
    assign port_b_oe = gen_out_en[15:8];
    assign port_d_oe = gen_out_en[18:16];

    // Idle sensing for turbo-off standby
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            lits_q <= '0;
            idle_cnt <= 2'h0;
        end else begin
            lits_q <= lits;
            if (lits != lits_q) begin
                idle_cnt <= 2'h0;
            end else if (idle_cnt < 2'(pgpld_pkg::PGPLD_IDLE_CYC)) begin
                idle_cnt <= idle_cnt + 2'h1;
            end
        end
    end
    // Turbo bit low means turbo off
    assign pld_standby = ~power_mode_reg_first[pgpld_pkg::PGPLD_TURBO_BIT]
        & (idle_cnt == 2'(pgpld_pkg::PGPLD_IDLE_CYC));

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_page_write;
        wr_act && page_hit;
    endsequence
    property p_page_load;
        s_page_write |=> page_bits == $past(data_in);
    endproperty
    a_page_load: assert property (p_page_load)
        else $error("page register missed a write");
    property p_page_hold;
        !(wr_act && page_hit) |=> $stable(page_bits);
    endproperty
    a_page_hold: assert property (p_page_hold)
        else $error("page register changed without a select");
    // Any read of a settled page must see the register itself
    sequence s_page_read;
        rd_act && page_hit && $stable(page_bits);
    endsequence
    property p_read_back;
        s_page_read |-> data_out == page_bits;
    endproperty
    a_read_back: assert property (p_read_back)
        else $error("read data differs from page register");
    property p_sec_over_main;
        |sec_raw |=> main_flash_select == 8'h00;
    endproperty
    a_sec_over_main: assert property (p_sec_over_main)
        else $error("main flash selected during secondary overlap");
    property p_sram_first;
        (sram_raw || reg_raw) |=> secondary_flash_select == 4'h0
            && main_flash_select == 8'h00;
    endproperty
    a_sram_first: assert property (p_sram_first)
        else $error("flash selected during sram or register access");
    property p_nonmux_port_a;
        nonmux |=> port_a_out == $past(page_bits);
    endproperty
    a_nonmux_port_a: assert property (p_nonmux_port_a)
        else $error("general output leaked onto data port");
    property p_standby_enter;
        (!power_mode_reg_first[pgpld_pkg::PGPLD_TURBO_BIT]
            && $stable(lits))[*3] |-> pld_standby;
    endproperty
    a_standby_enter: assert property (p_standby_enter)
        else $error("no standby after quiet inputs");
    property p_standby_exit;
        $changed(lits) |=> !pld_standby;
    endproperty
    a_standby_exit: assert property (p_standby_exit)
        else $error("standby held while inputs toggle");
    property p_burst_addr;
        bus_type == pgpld_pkg::PGPLD_BUS_BURST
            |-> in_bus[56:41] == addr_latch[19:4];
    endproperty
    a_burst_addr: assert property (p_burst_addr)
        else $error("burst mode used wrong address bits");
endmodule
